// ==== rtl/addr_map_pkg.sv ====
// Package with address map constants and carrier types for the decoder
package addr_map_pkg;

  // Address width and region boundaries
  localparam int ADDR_W = 32;
  localparam logic [31:0] USER_LAST = 32'h7FFF_FFFF;
  localparam logic [31:0] BOOT_FIRST = 32'h8000_0000;
  localparam logic [31:0] BOOT_LAST = 32'hBFFF_FFFF;
  localparam logic [31:0] SYS_FIRST = 32'hC000_0000;

  // ROM/external region 0x0000_0000..0x007F_FFFF, real part 4 MB
  localparam logic [31:0] ROMEXT_LAST = 32'h007F_FFFF;
  localparam int ROMEXT_REAL_BITS = 22;
  localparam int MB_BITS = 20;
  localparam int ROMEXT_TOP_BIT = 23;

  // Internal ROM sizes in KB
  localparam int ROM_KB_512 = 512;
  localparam int ROM_KB_384 = 384;
  localparam int ROM_KB_256 = 256;
  localparam int KB_BITS = 10;

  // RAM/peripheral region 0x0080_0000..0x00FF_FFFF, real part 128 KB
  localparam logic [31:0] RAMSFR_FIRST = 32'h0080_0000;
  localparam logic [31:0] RAMSFR_LAST = 32'h00FF_FFFF;
  localparam int RAMSFR_REAL_BITS = 17;
  localparam logic [16:0] SFR_OFS_FIRST = 17'h0_0000;
  localparam logic [16:0] SFR_OFS_LAST = 17'h0_3FFF;
  localparam logic [16:0] RAM_OFS_FIRST = 17'h0_4000;
  localparam logic [16:0] RAM_OFS_LAST = 17'h0_7FFF;

  // 1 MB slice index inside the real 4 MB of the ROM/external region
  localparam logic [1:0] SLICE0 = 2'h0;
  localparam logic [1:0] SLICE1 = 2'h1;
  localparam logic [1:0] SLICE2 = 2'h2;
  localparam logic [1:0] SLICE3 = 2'h3;

  // Operating modes, pin pair {a,b}
  typedef enum logic [2:0] {
    MODE_SINGLE  = 3'h0,
    MODE_EXTEND  = 3'h1,
    MODE_PROC    = 3'h3,
    MODE_FLASH   = 3'h2,
    MODE_RESERVE = 3'h6
  } opMode_t;

  // Region codes, binary encoded; selOneHot carries the one-hot select
  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_ROM  = 4'h1,
    REG_RAM  = 4'h2,
    REG_SFR  = 4'h3,
    REG_EXT0 = 4'h4,
    REG_EXT1 = 4'h5,
    REG_BOOT = 4'h6,
    REG_SYS  = 4'h7,
    REG_HOLE = 4'h8
  } region_t;

  // CPU request carrier
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } busReq_t;

  // Decode result carrier
  typedef struct packed {
    logic valid;
    region_t region;
    logic [31:0] addr;
    logic [31:0] localAddr;
    logic [6:0] selOneHot;
    logic ghost;
  } decodeRes_t;

endpackage

// ==== rtl/mcu_address_map_decoder.sv ====
// Registered address map decoder with strapped operating mode
`timescale 1ns/10ps
// Contract
// - Every address is a flat 32-bit value, no banks or segments.
// - 0x0000_0000..0x7FFF_FFFF is user space.
// - 0x8000_0000..0xBFFF_FFFF is boot-program space.
// - Mode pins: 00 single, 01 extension, 10 processor, 11 reserved.
// - Processor mode needs flash pin low; high gives flash rewrite mode.
// - Only ROM and external areas move with mode; rest is fixed.
// - ROM/external region is 8 MB; upper 4 MB ghosts the lower 4 MB.
// - Internal ROM starts at zero, 512, 384 or 256 KB long.
// - ROM start holds exception vectors then the interrupt vector table.
// - External windows and selects only in extension or processor mode.
// - Chip select low outputs follow the first and second windows.
// - Extension mode: window one 0x10_0000, window two 0x20_0000, 1 MB.
// - Extension mode: 0x30_0000..0x3F_FFFF ghosts window two.
// - Processor mode: window one at zero, window two 0x20_0000, 1 MB.
// - Processor mode: 0x10_0000 ghosts window one, 0x30_0000 window two.
// - RAM/peripheral region 8 MB; first 128 KB repeats every 128 KB.
// - 0x0080_4000..0x0080_7FFF is the 16 KB internal RAM, all modes.
// - Block from 0x0080_0000 below RAM is the peripheral register area.
module mcu_address_map_decoder #(
  parameter int ROM_KB = 512
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic modeSelectPinA,
  input wire logic modeSelectPinB,
  input wire logic flashProgramPin,
  input wire addr_map_pkg::busReq_t cpuReq,
  output addr_map_pkg::decodeRes_t decodeOut,
  output logic extWindowFirstLowN,
  output logic extWindowSecondLowN,
  output addr_map_pkg::opMode_t modeOut,
  output logic reservedModeErr
);
  import addr_map_pkg::*;

  // ===========================================================
  // State
  localparam logic [31:0] ROM_BYTES =
    32'(ROM_KB) << KB_BITS;

  typedef struct packed {
    logic [2:0] pinSync1;
    logic [2:0] pinSync2;
    opMode_t mode;
    logic modeErr;
    decodeRes_t res;
    logic cs0LowN;
    logic cs1LowN;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ===========================================================
  // Mode and address decode
  opMode_t modeNow;
  logic extOn;
  logic [1:0] slice;
  logic [31:0] romOfs;
  logic [16:0] ramOfs;
  decodeRes_t resNow;

  always_comb begin
    // Mode from synchronised pins; {a,b,flash}
    case (state_r.pinSync2[2:1])
      2'h0: modeNow = MODE_SINGLE;
      2'h1: modeNow = MODE_EXTEND;
      2'h2: modeNow = state_r.pinSync2[0] ? MODE_FLASH : MODE_PROC;
      default: modeNow = MODE_RESERVE;
    endcase
  end

  always_comb begin
    extOn = (state_r.mode == MODE_EXTEND) ||
            (state_r.mode == MODE_PROC);
    slice = cpuReq.addr[ROMEXT_REAL_BITS-1:MB_BITS];
    romOfs = {10'h000, cpuReq.addr[ROMEXT_REAL_BITS-1:0]};
    ramOfs = cpuReq.addr[RAMSFR_REAL_BITS-1:0];
    resNow = '0;
    resNow.valid = cpuReq.valid;
    resNow.addr = cpuReq.addr;
    resNow.region = REG_HOLE;
    resNow.localAddr = cpuReq.addr;
    if (cpuReq.addr >= SYS_FIRST) begin
      resNow.region = REG_SYS;
    end else if (cpuReq.addr >= BOOT_FIRST) begin
      resNow.region = REG_BOOT;
      resNow.localAddr = cpuReq.addr - BOOT_FIRST;
    end else if (cpuReq.addr <= ROMEXT_LAST) begin
      resNow.ghost = cpuReq.addr[ROMEXT_TOP_BIT-1];
      resNow.localAddr = romOfs;
      if (extOn && state_r.mode == MODE_EXTEND &&
          slice == SLICE1) begin
        resNow.region = REG_EXT0;
        resNow.localAddr = {12'h000, cpuReq.addr[MB_BITS-1:0]};
      end else if (extOn && state_r.mode == MODE_PROC &&
                   (slice == SLICE0 || slice == SLICE1)) begin
        resNow.region = REG_EXT0;
        resNow.ghost = resNow.ghost || (slice == SLICE1);
        resNow.localAddr = {12'h000, cpuReq.addr[MB_BITS-1:0]};
      end else if (extOn && (slice == SLICE2 || slice == SLICE3)) begin
        resNow.region = REG_EXT1;
        resNow.ghost = resNow.ghost || (slice == SLICE3);
        resNow.localAddr = {12'h000, cpuReq.addr[MB_BITS-1:0]};
      end else if (romOfs < ROM_BYTES) begin
        resNow.region = REG_ROM;
      end
    end else if (cpuReq.addr <= RAMSFR_LAST) begin
      resNow.ghost = (cpuReq.addr[ROMEXT_TOP_BIT-1:RAMSFR_REAL_BITS] != '0);
      resNow.localAddr = {15'h0000, ramOfs};
      if (ramOfs >= RAM_OFS_FIRST && ramOfs <= RAM_OFS_LAST) begin
        resNow.region = REG_RAM;
        resNow.localAddr = {15'h0000, ramOfs - RAM_OFS_FIRST};
      end else if (ramOfs <= SFR_OFS_LAST) begin
        resNow.region = REG_SFR;
      end
    end
    if (!cpuReq.valid) begin
      resNow.region = REG_NONE;
    end
    case (resNow.region)
      REG_ROM: resNow.selOneHot = 7'h01;
      REG_RAM: resNow.selOneHot = 7'h02;
      REG_SFR: resNow.selOneHot = 7'h04;
      REG_EXT0: resNow.selOneHot = 7'h08;
      REG_EXT1: resNow.selOneHot = 7'h10;
      REG_BOOT: resNow.selOneHot = 7'h20;
      REG_SYS: resNow.selOneHot = 7'h40;
      default: resNow.selOneHot = 7'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.pinSync1 = {modeSelectPinA, modeSelectPinB, flashProgramPin};
    state_nxt.pinSync2 = state_r.pinSync1;
    state_nxt.mode = modeNow;
    state_nxt.modeErr = (modeNow == MODE_RESERVE);
    state_nxt.res = resNow;
    state_nxt.cs0LowN = !(resNow.region == REG_EXT0);
    state_nxt.cs1LowN = !(resNow.region == REG_EXT1);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      state_r.mode <= MODE_SINGLE;
      state_r.res.region <= REG_NONE;
      state_r.cs0LowN <= 1'b1;
      state_r.cs1LowN <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ===========================================================
  // Outputs
  assign decodeOut = state_r.res;
  assign extWindowFirstLowN = state_r.cs0LowN;
  assign extWindowSecondLowN = state_r.cs1LowN;
  assign modeOut = state_r.mode;
  assign reservedModeErr = state_r.modeErr;

  // ===========================================================
  // Assertions
  property p_user_space;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr <= USER_LAST |=>
      decodeOut.region != REG_BOOT && decodeOut.region != REG_SYS;
  endproperty
  a_user_space: assert property (p_user_space)
    else $error("user address left user space");

  property p_boot;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr >= BOOT_FIRST && cpuReq.addr <= BOOT_LAST
      |=> decodeOut.region == REG_BOOT;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot address not decoded as boot");

  property p_single_noext;
    @(posedge clk_sys) disable iff (rst)
    modeOut == MODE_SINGLE |=> extWindowFirstLowN && extWindowSecondLowN;
  endproperty
  a_single_noext: assert property (p_single_noext)
    else $error("chip select in single-chip mode");

  property p_proc_mode;
    @(posedge clk_sys) disable iff (rst)
    modeSelectPinA && !modeSelectPinB && !flashProgramPin
      |-> ##3 modeOut == MODE_PROC;
  endproperty
  a_proc_mode: assert property (p_proc_mode)
    else $error("processor mode not reached");

  property p_cs_match;
    @(posedge clk_sys) disable iff (rst)
    !extWindowFirstLowN == (decodeOut.region == REG_EXT0) &&
    !extWindowSecondLowN == (decodeOut.region == REG_EXT1);
  endproperty
  a_cs_match: assert property (p_cs_match)
    else $error("chip select disagrees with region");

  property p_ext_win2;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && modeOut == MODE_EXTEND &&
      cpuReq.addr[31:MB_BITS] == 12'h003 |=> !extWindowSecondLowN;
  endproperty
  a_ext_win2: assert property (p_ext_win2)
    else $error("extension ghost of window two missed");

  property p_proc_win1;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && modeOut == MODE_PROC &&
      cpuReq.addr[31:MB_BITS] == 12'h000 |=> !extWindowFirstLowN;
  endproperty
  a_proc_win1: assert property (p_proc_win1)
    else $error("processor window one missed");

  property p_ram;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr[31:RAMSFR_REAL_BITS] == 15'h0040 &&
      cpuReq.addr[16:14] == 3'h1 |=> decodeOut.region == REG_RAM;
  endproperty
  a_ram: assert property (p_ram)
    else $error("internal RAM not selected");

  property p_onehot;
    @(posedge clk_sys) disable iff (rst)
    decodeOut.valid && decodeOut.region != REG_HOLE
      |-> $onehot(decodeOut.selOneHot);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("region select not exactly one");

  property p_mode_single;
    @(posedge clk_sys) disable iff (rst)
    !modeSelectPinA && !modeSelectPinB |-> ##3 modeOut == MODE_SINGLE;
  endproperty
  a_mode_single: assert property (p_mode_single)
    else $error("single-chip mode not reached");

  property p_mode_extend;
    @(posedge clk_sys) disable iff (rst)
    !modeSelectPinA && modeSelectPinB |-> ##3 modeOut == MODE_EXTEND;
  endproperty
  a_mode_extend: assert property (p_mode_extend)
    else $error("extension mode not reached");

  property p_flash_mode;
    @(posedge clk_sys) disable iff (rst)
    modeSelectPinA && !modeSelectPinB && flashProgramPin
      |-> ##3 modeOut == MODE_FLASH;
  endproperty
  a_flash_mode: assert property (p_flash_mode)
    else $error("flash rewrite mode not reached");

  property p_reserved;
    @(posedge clk_sys) disable iff (rst)
    modeSelectPinA && modeSelectPinB
      |-> ##3 reservedModeErr && modeOut == MODE_RESERVE;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved pin setting not flagged");

  property p_noext_other;
    @(posedge clk_sys) disable iff (rst)
    modeOut == MODE_FLASH || modeOut == MODE_RESERVE
      |=> extWindowFirstLowN && extWindowSecondLowN;
  endproperty
  a_noext_other: assert property (p_noext_other)
    else $error("chip select outside extension modes");

  property p_ext_win1;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && modeOut == MODE_EXTEND &&
      cpuReq.addr[31:MB_BITS] == 12'h001 |=> !extWindowFirstLowN;
  endproperty
  a_ext_win1: assert property (p_ext_win1)
    else $error("extension window one missed");

  property p_proc_ghost;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && modeOut == MODE_PROC &&
      cpuReq.addr[31:MB_BITS] == 12'h001
      |=> !extWindowFirstLowN && decodeOut.ghost;
  endproperty
  a_proc_ghost: assert property (p_proc_ghost)
    else $error("processor ghost of window one missed");

  property p_rom_ghost;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr[31:ROMEXT_TOP_BIT] == 9'h000 &&
      cpuReq.addr[ROMEXT_TOP_BIT-1] |=> decodeOut.ghost;
  endproperty
  a_rom_ghost: assert property (p_rom_ghost)
    else $error("upper ROM half not marked as ghost");

  property p_rom_base;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && modeOut != MODE_PROC && cpuReq.addr < ROM_BYTES
      |=> decodeOut.region == REG_ROM;
  endproperty
  a_rom_base: assert property (p_rom_base)
    else $error("internal ROM not selected");

  property p_ram_repeat;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr[31:ROMEXT_TOP_BIT] == 9'h001 &&
      cpuReq.addr[16:14] == 3'h1 |=> decodeOut.region == REG_RAM;
  endproperty
  a_ram_repeat: assert property (p_ram_repeat)
    else $error("RAM repeat not selected");

  property p_sfr;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr[31:14] == 18'h0_0200
      |=> decodeOut.region == REG_SFR;
  endproperty
  a_sfr: assert property (p_sfr)
    else $error("peripheral register area not selected");

  property p_sys;
    @(posedge clk_sys) disable iff (rst)
    cpuReq.valid && cpuReq.addr >= SYS_FIRST
      |=> decodeOut.region == REG_SYS && decodeOut.selOneHot == 7'h40;
  endproperty
  a_sys: assert property (p_sys)
    else $error("system space not selected");

  property p_idle;
    @(posedge clk_sys) disable iff (rst)
    !cpuReq.valid |=> decodeOut.region == REG_NONE &&
      decodeOut.selOneHot == 7'h00 && extWindowFirstLowN &&
      extWindowSecondLowN;
  endproperty
  a_idle: assert property (p_idle)
    else $error("select seen without a request");

  c_ext0: cover property (@(posedge clk_sys) !extWindowFirstLowN);
  c_ext1: cover property (@(posedge clk_sys) !extWindowSecondLowN);
  c_ram_ghost: cover property (@(posedge clk_sys)
    decodeOut.region == REG_RAM && decodeOut.ghost);
  c_rom: cover property (@(posedge clk_sys) decodeOut.region == REG_ROM);
  c_proc_ghost: cover property (@(posedge clk_sys)
    modeOut == MODE_PROC && decodeOut.ghost && !extWindowFirstLowN);

endmodule

// ==== tb/ext_device_model.sv ====
// Model of the two external devices behind the chip selects
`timescale 1ns/10ps
module ext_device_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic firstLowN,
  input wire logic secondLowN,
  output logic [7:0] firstHits,
  output logic [7:0] secondHits
);
  // Each device counts the cycles in which it is selected
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      firstHits <= 8'h00;
      secondHits <= 8'h00;
    end else begin
      if (!firstLowN) begin
        firstHits <= firstHits + 8'h01;
      end
      if (!secondLowN) begin
        secondHits <= secondHits + 8'h01;
      end
    end
  end
endmodule

// ==== tb/test_mcu_address_map_decoder.sv ====
// Testbench for the address map decoder
`timescale 1ns/10ps
module test_mcu_address_map_decoder;
  import addr_map_pkg::*;
  logic clk_sys, rst, modeSelectPinA, modeSelectPinB, flashProgramPin;
  logic extWindowFirstLowN, extWindowSecondLowN, reservedModeErr;
  logic [7:0] firstHits, secondHits, expFirst, expSecond;
  busReq_t cpuReq;
  decodeRes_t decodeOut;
  opMode_t modeOut;
  int errors, cmp_count, cycles;

  mcu_address_map_decoder #(.ROM_KB(384)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .modeSelectPinA(modeSelectPinA),
    .modeSelectPinB(modeSelectPinB), .flashProgramPin(flashProgramPin),
    .cpuReq(cpuReq), .decodeOut(decodeOut),
    .extWindowFirstLowN(extWindowFirstLowN),
    .extWindowSecondLowN(extWindowSecondLowN),
    .modeOut(modeOut), .reservedModeErr(reservedModeErr));
  ext_device_model u_ext (
    .clk_sys(clk_sys), .rst(rst), .firstLowN(extWindowFirstLowN),
    .secondLowN(extWindowSecondLowN), .firstHits(firstHits),
    .secondHits(secondHits));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmpVal(input string n, input logic [31:0] e,
                        input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmpBit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // One request, answer judged one cycle later
  task automatic access(input logic [31:0] a, input region_t r,
                        input logic gh);
    logic [6:0] expSel;
    expSel = 7'h00;
    if (r != REG_NONE && r != REG_HOLE) expSel = 7'h01 << (r - 4'h1);
    @(negedge clk_sys);
    cpuReq = '{valid: 1'b1, addr: a};
    @(negedge clk_sys);
    cpuReq.valid = 1'b0;
    cmpVal("region", {28'h0, r}, {28'h0, decodeOut.region});
    cmpBit("ghost", gh, decodeOut.ghost);
    cmpBit("csFirst", r != REG_EXT0, extWindowFirstLowN);
    cmpBit("csSecond", r != REG_EXT1, extWindowSecondLowN);
    cmpBit("valid", 1'b1, decodeOut.valid);
    cmpVal("addr", a, decodeOut.addr);
    cmpVal("select", {25'h0, expSel},
           {25'h0, decodeOut.selOneHot});
    if (r == REG_EXT0) expFirst++;
    if (r == REG_EXT1) expSecond++;
  endtask

  // Request whose offset into the target is judged as well
  task automatic accessLocal(input logic [31:0] a, input region_t r,
                             input logic gh, input logic [31:0] loc);
    access(a, r, gh);
    cmpVal("localAddr", loc, decodeOut.localAddr);
  endtask

  task automatic setMode(input logic a, input logic b, input logic f,
                         input opMode_t m, input logic err);
    @(negedge clk_sys);
    modeSelectPinA = a;
    modeSelectPinB = b;
    flashProgramPin = f;
    repeat (4) @(negedge clk_sys);
    cmpVal("mode", {29'h0, m}, {29'h0, modeOut});
    cmpBit("reservedErr", err, reservedModeErr);
  endtask

  task automatic testSpaces;
    access(32'h0100_0000, REG_HOLE, 1'b0);
    access(32'h7FFF_FFFF, REG_HOLE, 1'b0);
    access(32'h8000_0000, REG_BOOT, 1'b0);
    accessLocal(32'hBFFF_FFFF, REG_BOOT, 1'b0, 32'h3FFF_FFFF);
    access(32'hC000_0000, REG_SYS, 1'b0);
    access(32'hFFFF_FFFF, REG_SYS, 1'b0);
    @(negedge clk_sys);
    cmpVal("idle", {28'h0, REG_NONE}, {28'h0, decodeOut.region});
  endtask

  task automatic testRamSfr;
    access(32'h0080_0000, REG_SFR, 1'b0);
    accessLocal(32'h0080_3FFF, REG_SFR, 1'b0, 32'h0000_3FFF);
    access(32'h0080_4000, REG_RAM, 1'b0);
    accessLocal(32'h0080_7FFF, REG_RAM, 1'b0, 32'h0000_3FFF);
    access(32'h0080_8000, REG_HOLE, 1'b0);
    access(32'h00FE_4000, REG_RAM, 1'b1);
  endtask

  task automatic testSingle;
    access(32'h0000_0000, REG_ROM, 1'b0);
    accessLocal(32'h0005_FFFF, REG_ROM, 1'b0, 32'h0005_FFFF);
    access(32'h0006_0000, REG_HOLE, 1'b0);
    access(32'h0010_0000, REG_HOLE, 1'b0);
    accessLocal(32'h0040_0000, REG_ROM, 1'b1, 32'h0000_0000);
  endtask

  task automatic testExtend;
    setMode(1'b0, 1'b1, 1'b0, MODE_EXTEND, 1'b0);
    access(32'h0000_0000, REG_ROM, 1'b0);
    access(32'h0010_0000, REG_EXT0, 1'b0);
    access(32'h001F_FFFF, REG_EXT0, 1'b0);
    access(32'h0020_0000, REG_EXT1, 1'b0);
    accessLocal(32'h0030_0004, REG_EXT1, 1'b1, 32'h0000_0004);
    access(32'h0050_0000, REG_EXT0, 1'b1);
    access(32'h0080_4000, REG_RAM, 1'b0);
  endtask

  task automatic testProc;
    setMode(1'b1, 1'b0, 1'b0, MODE_PROC, 1'b0);
    access(32'h0000_0000, REG_EXT0, 1'b0);
    accessLocal(32'h000F_FFFF, REG_EXT0, 1'b0, 32'h000F_FFFF);
    access(32'h0010_0000, REG_EXT0, 1'b1);
    access(32'h002F_FFFF, REG_EXT1, 1'b0);
    access(32'h003F_FFFF, REG_EXT1, 1'b1);
    access(32'h0080_0000, REG_SFR, 1'b0);
  endtask

  task automatic testFlashReserved;
    setMode(1'b1, 1'b0, 1'b1, MODE_FLASH, 1'b0);
    access(32'h0000_0000, REG_ROM, 1'b0);
    access(32'h0020_0000, REG_HOLE, 1'b0);
    setMode(1'b1, 1'b1, 1'b0, MODE_RESERVE, 1'b1);
    access(32'h0010_0000, REG_HOLE, 1'b0);
    setMode(1'b0, 1'b0, 1'b0, MODE_SINGLE, 1'b0);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    expFirst = 8'h00;
    expSecond = 8'h00;
    rst = 1'b1;
    modeSelectPinA = 1'b0;
    modeSelectPinB = 1'b0;
    flashProgramPin = 1'b0;
    cpuReq = '0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    testSpaces();
    testRamSfr();
    testSingle();
    testExtend();
    testProc();
    testFlashReserved();
    cmpVal("hitsFirst", {24'h0, expFirst}, {24'h0, firstHits});
    cmpVal("hitsSecond", {24'h0, expSecond}, {24'h0, secondHits});
    complete_run();
  end
endmodule
